// File: rtl/psa_pkg.sv
// package: opcodes, lane geometry and saturation bounds for the packed simd alu
package psa_pkg;
  // operand width, lane widths and opcode width
  localparam int PSA_DATA_W = 64;
  localparam int PSA_BYTE_W = 8;
  localparam int PSA_WORD_W = 16;
  localparam int PSA_OP_W = 5;
  // signed word saturation bounds, per-lane values of the packed max and min constants
  localparam logic [15:0] PSA_SW_MAX = 16'h7fff;
  localparam logic [15:0] PSA_SW_MIN = 16'h8000;
  // unsigned word bounds, then signed and unsigned byte saturation bounds
  localparam logic [15:0] PSA_UW_MAX = 16'hffff;
  localparam logic [15:0] PSA_UW_MIN = 16'h0000;
  localparam logic [7:0] PSA_SB_MAX = 8'h7f;
  localparam logic [7:0] PSA_SB_MIN = 8'h80;
  localparam logic [7:0] PSA_UB_MAX = 8'hff;
  localparam logic [7:0] PSA_UB_MIN = 8'h00;
  // reset value of the result register
  localparam logic [63:0] PSA_RES_RST = 64'h0000_0000_0000_0000;
  // operation codes
  typedef enum logic [4:0] {
    PSA_OP_MAXSW   = 5'h00,
    PSA_OP_MINSW   = 5'h01,
    PSA_OP_MAXUB   = 5'h02,
    PSA_OP_MINUB   = 5'h03,
    PSA_OP_MULHUW  = 5'h04,
    PSA_OP_MULHSW  = 5'h05,
    PSA_OP_ADDW    = 5'h06,
    PSA_OP_SUBW    = 5'h07,
    PSA_OP_ADDSSW  = 5'h08,
    PSA_OP_SUBSSW  = 5'h09,
    PSA_OP_ADDUSW  = 5'h0a,
    PSA_OP_SUBUSW  = 5'h0b,
    PSA_OP_ADDSSB  = 5'h0c,
    PSA_OP_SUBSSB  = 5'h0d,
    PSA_OP_ADDUSB  = 5'h0e,
    PSA_OP_SUBUSB  = 5'h0f,
    PSA_OP_CMPGTW  = 5'h10,
    PSA_OP_CMPEQW  = 5'h11,
    PSA_OP_XOR     = 5'h12,
    PSA_OP_AND     = 5'h13
  } psa_op_t;
endpackage

// File: rtl/psa_word_lane.sv
// one 16-bit word lane: max/min, multiply-high, add/subtract, compare
module psa_word_lane
  import psa_pkg::*;
(
  input wire logic [15:0] dst,
  input wire logic [15:0] src,
  input wire logic [4:0] op,
  output logic [15:0] res,
  output logic hit
);
  // extended sums: signed and unsigned views with one extra bit
  logic signed [16:0] s_add;
  logic signed [16:0] s_sub;
  logic [16:0] u_add;
  logic [16:0] u_sub;
  logic signed [31:0] s_prod;
  logic [31:0] u_prod;
  logic gt_s;

  assign s_add = 17'($signed(dst)) + 17'($signed(src));
  assign s_sub = 17'($signed(dst)) - 17'($signed(src)); // source taken as signed
  assign u_add = {1'b0, dst} + {1'b0, src};
  assign u_sub = {1'b0, dst} - {1'b0, src};
  assign s_prod = $signed(dst) * $signed(src);
  assign u_prod = dst * src;
  assign gt_s = $signed(dst) > $signed(src);

  // per-lane result mux; lane never looks at its neighbours
  always_comb begin
    hit = 1'b1;
    case (op)
      PSA_OP_MAXSW: res = gt_s ? dst : src;
      PSA_OP_MINSW: res = gt_s ? src : dst;
      PSA_OP_MULHUW: res = u_prod[31:16];
      PSA_OP_MULHSW: res = s_prod[31:16];
      PSA_OP_ADDW: res = u_add[15:0];
      PSA_OP_SUBW: res = u_sub[15:0];
      PSA_OP_ADDSSW: begin
        // overflow shows as bits 16 and 15 disagreeing
        if (s_add[16] != s_add[15]) res = s_add[16] ? PSA_SW_MIN : PSA_SW_MAX;
        else res = s_add[15:0];
      end
      PSA_OP_SUBSSW: begin
        if (s_sub[16] != s_sub[15]) res = s_sub[16] ? PSA_SW_MIN : PSA_SW_MAX;
        else res = s_sub[15:0];
      end
      PSA_OP_ADDUSW: res = u_add[16] ? PSA_UW_MAX : u_add[15:0];
      PSA_OP_SUBUSW: res = u_sub[16] ? PSA_UW_MIN : u_sub[15:0];
      PSA_OP_CMPGTW: res = gt_s ? PSA_UW_MAX : PSA_UW_MIN;
      PSA_OP_CMPEQW: res = (dst == src) ? PSA_UW_MAX : PSA_UW_MIN;
      default: begin
        // not a word operation: the top picks another path
        res = PSA_UW_MIN;
        hit = 1'b0;
      end
    endcase
  end
endmodule

// File: rtl/psa_alu.sv
// top: packed simd integer alu with registered one-cycle result
module psa_alu
  import psa_pkg::*;
#(
  parameter int WORD_LANES = 4,
  parameter int BYTE_LANES = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [4:0] in_op,
  input wire logic [63:0] in_dst,
  input wire logic [63:0] in_src,
  output logic out_valid,
  output logic out_illegal,
  output logic [63:0] out_result
);
  // lane counts must tile the 64-bit operand exactly
  if (WORD_LANES * PSA_WORD_W != PSA_DATA_W || BYTE_LANES * PSA_BYTE_W != PSA_DATA_W) begin
    $error("psa_alu: lane counts must tile the operand width");
  end

  logic [63:0] word_res; // concatenated word lane results
  logic [WORD_LANES-1:0] word_hit; // word lane recognised the opcode
  wire logic [63:0] byte_res; // concatenated byte lane results, one driver per slice
  logic byte_hit; // byte operation selected
  logic [63:0] next_result; // value loaded into out_result
  logic next_illegal; // opcode matched no path

  // word lanes are independent instances
  for (genvar w = 0; w < WORD_LANES; w++) begin : g_word
    psa_word_lane u_lane (
      .dst(in_dst[w*PSA_WORD_W +: PSA_WORD_W]),
      .src(in_src[w*PSA_WORD_W +: PSA_WORD_W]),
      .op(in_op),
      .res(word_res[w*PSA_WORD_W +: PSA_WORD_W]),
      .hit(word_hit[w])
    );
  end

  // byte lanes: unsigned max/min and byte saturating add/sub
  for (genvar b = 0; b < BYTE_LANES; b++) begin : g_byte
    logic [7:0] d; // destination byte
    logic [7:0] s; // source byte
    logic [8:0] ua; // unsigned sum with carry
    logic [8:0] us; // unsigned difference with borrow
    logic signed [8:0] sa; // signed sum, one guard bit
    logic signed [8:0] ss; // signed difference, one guard bit
    logic [7:0] r; // this lane's selected result
    assign d = in_dst[b*PSA_BYTE_W +: PSA_BYTE_W];
    assign s = in_src[b*PSA_BYTE_W +: PSA_BYTE_W];
    assign ua = {1'b0, d} + {1'b0, s};
    assign us = {1'b0, d} - {1'b0, s};
    assign sa = 9'($signed(d)) + 9'($signed(s));
    assign ss = 9'($signed(d)) - 9'($signed(s));
    // select per lane; the subtract with unsigned clamp sees unsigned inputs only
    always_comb begin
      case (in_op)
        PSA_OP_MAXUB: r = (d > s) ? d : s;
        PSA_OP_MINUB: r = (d < s) ? d : s;
        PSA_OP_ADDUSB: r = ua[8] ? PSA_UB_MAX : ua[7:0];
        PSA_OP_SUBUSB: r = us[8] ? PSA_UB_MIN : us[7:0];
        PSA_OP_ADDSSB: begin
          if (sa[8] != sa[7]) r = sa[8] ? PSA_SB_MIN : PSA_SB_MAX;
          else r = sa[7:0];
        end
        PSA_OP_SUBSSB: begin
          if (ss[8] != ss[7]) r = ss[8] ? PSA_SB_MIN : PSA_SB_MAX;
          else r = ss[7:0];
        end
        default: r = PSA_UB_MIN;
      endcase
    end
    // each lane owns only its own slice, so the vector has one driver per bit
    assign byte_res[b*PSA_BYTE_W +: PSA_BYTE_W] = r;
  end

  // byte path owns these six opcodes; no doubleword saturating forms exist
  always_comb begin
    case (in_op)
      PSA_OP_MAXUB, PSA_OP_MINUB, PSA_OP_ADDUSB,
      PSA_OP_SUBUSB, PSA_OP_ADDSSB, PSA_OP_SUBSSB: byte_hit = 1'b1;
      default: byte_hit = 1'b0;
    endcase
  end

  // final selection across word, byte and bitwise paths
  always_comb begin
    next_illegal = 1'b0;
    // all word lanes decode the same opcode, so every hit bit agrees
    if (&word_hit) begin
      next_result = word_res;
    end else if (byte_hit) begin
      next_result = byte_res;
    end else begin
      case (in_op)
        PSA_OP_XOR: next_result = in_dst ^ in_src;
        PSA_OP_AND: next_result = in_dst & in_src; // mask select after compare
        default: begin
          // unknown opcode yields zero and flags it rather than stale data
          next_result = PSA_RES_RST;
          next_illegal = 1'b1;
        end
      endcase
    end
  end

  // result register: loaded only on a valid strobe, held otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      out_result <= PSA_RES_RST;
      out_illegal <= 1'b0;
    end else if (in_valid) begin
      out_result <= next_result;
      out_illegal <= next_illegal;
    end
  end

  // valid follows the strobe by exactly one cycle
  always_ff @(posedge clk) begin
    if (rst) out_valid <= 1'b0;
    else out_valid <= in_valid;
  end
endmodule

// File: tb/psa_alu_asserts.sv
// checker: port-level timing and result properties of the packed simd alu
module psa_alu_asserts
  import psa_pkg::*;
#(
  parameter int WORD_LANES = 4,
  parameter int BYTE_LANES = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [4:0] in_op,
  input wire logic [63:0] in_dst,
  input wire logic [63:0] in_src,
  input wire logic out_valid,
  input wire logic out_illegal,
  input wire logic [63:0] out_result
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // top bit of every word lane, the signed offset constant
  localparam logic [63:0] MSB_W = 64'h8000_8000_8000_8000;
  resp_lat_a: assert property (in_valid |=> out_valid) else $error("no answer");
  no_spur_a: assert property (!in_valid |=> !out_valid) else $error("stray answer");
  res_hold_a: assert property (!in_valid |=> $stable(out_result)) else $error("no hold");
  illegal_flag_a: assert property (in_valid |=> out_illegal == ($past(in_op) > 5'h13))
    else $error("illegal flag wrong");
  xor_self_a: assert property (in_valid && in_op == PSA_OP_XOR && in_dst == in_src
    |=> out_result == 64'h0) else $error("xor self not zero");
  eq_self_a: assert property (in_valid && in_op == PSA_OP_CMPEQW && in_dst == in_src
    |=> out_result == 64'hffff_ffff_ffff_ffff) else $error("eq self not ones");
  sub_wrap_a: assert property (in_valid && in_op == PSA_OP_SUBW && in_dst == 64'h0
    && in_src == MSB_W |=> out_result == MSB_W) else $error("sub no wrap");
  add_off_a: assert property (in_valid && in_op == PSA_OP_ADDW && in_src == MSB_W
    |=> out_result == ($past(in_dst) ^ MSB_W)) else $error("add offset wrong");
  and_mask_a: assert property (in_valid && in_op == PSA_OP_AND
    |=> out_result == ($past(in_dst) & $past(in_src))) else $error("and wrong");
endmodule
bind psa_alu psa_alu_asserts #(.WORD_LANES(WORD_LANES), .BYTE_LANES(BYTE_LANES)) chk_i (
  .clk(clk), .rst(rst), .in_valid(in_valid), .in_op(in_op), .in_dst(in_dst), .in_src(in_src),
  .out_valid(out_valid), .out_illegal(out_illegal), .out_result(out_result));

// File: tb/psa_pipe_model.sv
// partner: pipeline stage issuing packed operands to the alu
module psa_pipe_model (
  input wire logic clk,
  output logic in_valid,
  output logic [4:0] in_op,
  output logic [63:0] in_dst,
  output logic [63:0] in_src
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    in_valid = 1'b0;
    in_op = 5'h00;
    in_dst = 64'h0;
    in_src = 64'h0;
  end
  // one request per cycle, launched on the falling edge
  task automatic issue(input logic [4:0] op, input logic [63:0] d, input logic [63:0] s);
    @(negedge clk);
    in_valid = 1'b1;
    in_op = op;
    in_dst = d;
    in_src = s;
  endtask
  // idle operands turn inverse so a stale value is never trusted
  task automatic idle();
    @(negedge clk);
    in_valid = 1'b0;
    in_op = ~in_op;
    in_dst = ~in_dst;
    in_src = ~in_src;
  endtask
endmodule

// File: tb/testbench.sv
// testbench: scoreboarded directed and random traffic for the packed simd alu
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid, out_valid, out_illegal;
  logic [4:0] in_op;
  logic [63:0] in_dst, in_src, out_result;
  logic [64:0] exp_q[$]; // expected {illegal, result}, oldest first
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  integer seed = 32'hc6a233a4;
  always #12.5 clk = ~clk;
  psa_pipe_model pipe (.clk(clk), .in_valid(in_valid), .in_op(in_op), .in_dst(in_dst),
    .in_src(in_src));
  psa_alu uut (.clk(clk), .rst(rst), .in_valid(in_valid), .in_op(in_op), .in_dst(in_dst),
    .in_src(in_src), .out_valid(out_valid), .out_illegal(out_illegal), .out_result(out_result));
  // lane model: sign-extend signed lanes, compute wide, then saturate or wrap
  function automatic logic [64:0] ref_f(input logic [4:0] op, input logic [63:0] d, s);
    longint x, y, v, m, lo, hi;
    int w;
    logic [63:0] r;
    bit sg;
    w = (op inside {2, 3, [12:15]}) ? 8 : 16;
    sg = op inside {0, 1, 5, 8, 9, 12, 13, 16};
    m = (longint'(1) << w) - 1;
    lo = sg ? -(m + 1) / 2 : 0;
    hi = sg ? m / 2 : m;
    r = 64'h0;
    if (op > 19) return {1'b1, 64'h0};
    if (op == 18) return {1'b0, d ^ s};
    if (op == 19) return {1'b0, d & s};
    for (int i = 0; i < 64 / w; i++) begin
      x = (d >> (i * w)) & m;
      y = (s >> (i * w)) & m;
      if (sg && x > hi) x -= m + 1;
      if (sg && y > hi) y -= m + 1;
      case (op)
        0, 2: v = x > y ? x : y;
        1, 3: v = x < y ? x : y;
        4, 5: v = (x * y) >>> 16;
        6, 8, 10, 12, 14: v = x + y;
        16: v = x > y ? -1 : 0;
        17: v = x == y ? -1 : 0;
        default: v = x - y;
      endcase
      if (op >= 8 && op <= 15) v = v > hi ? hi : (v < lo ? lo : v);
      r |= 64'(v & m) << (i * w);
    end
    return {1'b0, r};
  endfunction
  task automatic chk(input logic [64:0] e, input logic [64:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic summarize();
    $display("counts: %0d checked, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input logic [4:0] op, input logic [63:0] d, input logic [63:0] s);
    exp_q.push_back(ref_f(op, d, s));
    pipe.issue(op, d, s);
  endtask
  // watcher: settled outputs after each edge, plus a hang limit
  always @(posedge clk) begin
    #1;
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      summarize();
    end
    if (out_valid !== 1'b0)
      chk(exp_q.size() ? exp_q.pop_front() : 65'bx, {out_illegal, out_result});
  end
  initial begin
    logic [63:0] d, s;
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    // every code, back to back, with wrap, self and clamp corners
    for (int op = 0; op < 32; op++)
      for (int k = 0; k < 4; k++) begin
        d = {$random(seed), $random(seed)};
        s = k == 1 ? d : {$random(seed), $random(seed)};
        if (k == 0) {d, s} = {64'h0, 64'h8000_8000_8000_8000};
        if (k == 2) {d, s} = {64'h7fff_8000_ffff_0001, 64'h0001_8001_0002_ffff};
        send(5'(op), d, s);
      end
    pipe.idle();
    $display("directed test done");
    // random codes and operands with random idle gaps
    repeat (400) begin
      send(5'({$random(seed)} % 22), {$random(seed), $random(seed)}, {$random(seed), $random(seed)});
      if ($random(seed) & 1) pipe.idle();
    end
    pipe.idle();
    repeat (4) @(negedge clk);
    chk(65'(exp_q.size()), 65'h0);
    $display("random test done");
    // mid-run reset clears the result register and no answer stands during it
    send(5'h12, 64'h0, {$random(seed), $random(seed)} | 64'h1);
    pipe.idle();
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    chk({out_illegal, out_result}, 65'h0);
    chk(65'(out_valid), 65'h0);
    rst = 1'b0;
    // first requests right after the release must be taken normally
    send(5'h15, {$random(seed), $random(seed)}, 64'h0);
    send(5'h13, 64'hffff_0000_ffff_0000, 64'h1234_5678_9abc_def0);
    pipe.idle();
    repeat (4) @(negedge clk);
    chk(65'(exp_q.size()), 65'h0);
    $display("reset test done");
    summarize();
  end
endmodule
